// ==== rtl/flash_fe_cfg.svh ====
`ifndef FLASH_FE_CFG_SVH
`define FLASH_FE_CFG_SVH
`define OPC_RD 8'h03
`define OPC_FRD 8'h0b
`define OPC_DRD 8'h3b
`define OPC_DIORD 8'hbb
`define OPC_QRD 8'h6b
`define OPC_QIORD 8'heb
`define OPC_WQIORD 8'he7
`define OPC_PP 8'h02
`define OPC_QPP 8'h32
`define OPC_BE4 8'h20
`define OPC_BE32 8'h52
`define OPC_BE64 8'hd8
`define OPC_SUS 8'h75
`define OPC_RES 8'h7a
`define OPC_RSR1 8'h05
`define OPC_RSR2 8'h35
`define OPC_RSR3 8'h15
`define OPC_WSR1 8'h01
`define OPC_WSR2 8'h31
`define OPC_WSR3 8'h11
`define OPC_ID1 8'h90
`define OPC_ID2 8'h92
`define OPC_ID4 8'h94
`define OPC_JID 8'h9f
`define OPC_PARAM 8'h5a
`define OPC_SECE 8'h44
`define OPC_SECP 8'h42
`define OPC_SECR 8'h48
`define OPC_UID 8'h4b
`define OPC_SYS_LIST 8'h66, 8'h99, 8'hb9, 8'hab, 8'h06, 8'h50, 8'h04, 8'hc7, 8'h60
`define W0 3'h0
`define W1 3'h1
`define W2 3'h2
`define W4 3'h4
`define OPC_CLK 6'h08
`define ADDR_CLK_1L 6'h18
`define ADDR_CLK_2L 6'h0c
`define ADDR_CLK_4L 6'h06
`define NO_MODE 3'h0
`define MODE_CLK_2L 3'h4
`define MODE_CLK_4L 3'h2
`define NO_DUMMY 6'h00
`define DUMMY_2 6'h02
`define DUMMY_4 6'h04
`define DUMMY_8 6'h08
`define DUMMY_32 6'h20
`define BYTE_BITS 4'h8
`define NO_BITS 4'h0
`define PHASE_LAST 6'h01
`define MAX_UNL 2'h0
`define MAX_1 2'h1
`define MAX_2 2'h2
`define MAX_3 2'h3
`define OE_1L 4'h2
`define OE_2L 4'h3
`define OE_4L 4'hf
`define ADDR_TOP 22'h3fffff
`define SYNC_INIT 6'h01
`endif

// ==== rtl/flash_fe_pkg.sv ====
package flash_fe_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC = 3'b001,
    ST_ADDR = 3'b010,
    ST_MODE = 3'b011,
    ST_DUMMY = 3'b100,
    ST_DIN = 3'b101,
    ST_DOUT = 3'b110,
    ST_IGNORE = 3'b111
  } fe_state_t;
  typedef struct packed {
    logic known;
    logic [2:0] adW;
    logic [2:0] modeClk;
    logic [5:0] dummyClk;
    logic [2:0] daW;
    logic dirOut;
    logic [1:0] maxBytes;
  } cmd_desc_t;
  typedef struct packed {
    fe_state_t st;
    logic [5:0] cnt;
  } phase_step_t;
  typedef struct packed {
    logic [7:0] opcode;
    logic [21:0] addr;
  } cmd_t;
  typedef struct packed {
    logic [3:0] dat;
    logic [3:0] oe;
  } lane_drive_t;
endpackage

// ==== rtl/sync_2ff.sv ====
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // Level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q <= INIT;
    end else if (en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ==== rtl/edge_finder.sv ====
`timescale 1ns/1ps
module edge_finder #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // Synchronised level and its edges
  input wire logic lvl,
  output logic rise,
  output logic fall
);
  logic prev_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= INIT;
    end else if (en) begin
      prev_r <= lvl;
    end
  end
  assign rise = lvl & ~prev_r;
  assign fall = ~lvl & prev_r;
endmodule

// ==== rtl/serial_flash_front_end.sv ====
`timescale 1ns/1ps
`include "flash_fe_cfg.svh"
module serial_flash_front_end (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // Serial link pins
  input wire logic csN,
  input wire logic sck,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  // Array and information read side
  output logic [21:0] rdAddr,
  output logic [7:0] rdSrc,
  input wire logic [7:0] rdByte,
  // Decoded commands and write data
  output logic cmdValid,
  output flash_fe_pkg::cmd_t cmd,
  output logic wrValid,
  output logic [7:0] wrByte
);

  // ==========================================================
  // Command table
  // ==========================================================
  function automatic flash_fe_pkg::cmd_desc_t mk(
    input logic [2:0] adW,
    input logic [2:0] modeClk,
    input logic [5:0] dummyClk,
    input logic [2:0] daW,
    input logic dirOut,
    input logic [1:0] maxBytes
  );
    flash_fe_pkg::cmd_desc_t d;
    d.known = 1'b1;
    d.adW = adW;
    d.modeClk = modeClk;
    d.dummyClk = dummyClk;
    d.daW = daW;
    d.dirOut = dirOut;
    d.maxBytes = maxBytes;
    return d;
  endfunction

  // Each entry is the address and data widths and direction plus mode, dummy and byte limit.
  function automatic flash_fe_pkg::cmd_desc_t decode(input logic [7:0] op);
    flash_fe_pkg::cmd_desc_t d;
    d = '0;
    case (op)
      `OPC_SYS_LIST, `OPC_SUS, `OPC_RES: begin
        d = mk(`W0, `NO_MODE, `NO_DUMMY, `W0, 1'b0, `MAX_UNL);
      end
      `OPC_RD: begin
        d = mk(`W1, `NO_MODE, `NO_DUMMY, `W1, 1'b1, `MAX_UNL);
      end
      `OPC_FRD: begin
        d = mk(`W1, `NO_MODE, `DUMMY_8, `W1, 1'b1, `MAX_UNL);
      end
      `OPC_DRD: begin
        d = mk(`W1, `NO_MODE, `DUMMY_8, `W2, 1'b1, `MAX_UNL);
      end
      `OPC_DIORD: begin
        d = mk(`W2, `MODE_CLK_2L, `NO_DUMMY, `W2, 1'b1, `MAX_UNL);
      end
      `OPC_QRD: begin
        d = mk(`W1, `NO_MODE, `DUMMY_8, `W4, 1'b1, `MAX_UNL);
      end
      `OPC_QIORD: begin
        d = mk(`W4, `MODE_CLK_4L, `DUMMY_4, `W4, 1'b1, `MAX_UNL);
      end
      `OPC_WQIORD: begin
        d = mk(`W4, `MODE_CLK_4L, `DUMMY_2, `W4, 1'b1, `MAX_UNL);
      end
      `OPC_PP, `OPC_SECP: begin
        d = mk(`W1, `NO_MODE, `NO_DUMMY, `W1, 1'b0, `MAX_UNL);
      end
      `OPC_QPP: begin
        d = mk(`W1, `NO_MODE, `NO_DUMMY, `W4, 1'b0, `MAX_UNL);
      end
      `OPC_BE4, `OPC_BE32, `OPC_BE64, `OPC_SECE: begin
        d = mk(`W1, `NO_MODE, `NO_DUMMY, `W0, 1'b0, `MAX_UNL);
      end
      `OPC_RSR1, `OPC_RSR2, `OPC_RSR3: begin
        d = mk(`W0, `NO_MODE, `NO_DUMMY, `W1, 1'b1, `MAX_1);
      end
      `OPC_WSR1, `OPC_WSR2, `OPC_WSR3: begin
        d = mk(`W0, `NO_MODE, `NO_DUMMY, `W1, 1'b0, `MAX_1);
      end
      `OPC_ID1: begin
        d = mk(`W1, `NO_MODE, `NO_DUMMY, `W1, 1'b1, `MAX_2);
      end
      `OPC_ID2: begin
        d = mk(`W2, `NO_MODE, `DUMMY_4, `W2, 1'b1, `MAX_2);
      end
      `OPC_ID4: begin
        d = mk(`W4, `NO_MODE, `DUMMY_4, `W4, 1'b1, `MAX_2);
      end
      `OPC_JID: begin
        d = mk(`W0, `NO_MODE, `NO_DUMMY, `W1, 1'b1, `MAX_3);
      end
      `OPC_PARAM, `OPC_SECR: begin
        d = mk(`W1, `NO_MODE, `DUMMY_8, `W1, 1'b1, `MAX_UNL);
      end
      `OPC_UID: begin
        d = mk(`W0, `NO_MODE, `DUMMY_32, `W1, 1'b1, `MAX_UNL);
      end
      default: begin
        d.known = 1'b0;
      end
    endcase
    return d;
  endfunction

  // Phases run address, mode, dummy, data; absent ones are skipped.
  function automatic flash_fe_pkg::phase_step_t nextPhase(
    input flash_fe_pkg::fe_state_t cur,
    input flash_fe_pkg::cmd_desc_t d
  );
    flash_fe_pkg::phase_step_t s;
    s.st = flash_fe_pkg::ST_IGNORE;
    s.cnt = '0;
    if (cur == flash_fe_pkg::ST_OPC && d.adW != `W0) begin
      s.st = flash_fe_pkg::ST_ADDR;
      case (d.adW)
        `W2: s.cnt = `ADDR_CLK_2L;
        `W4: s.cnt = `ADDR_CLK_4L;
        default: s.cnt = `ADDR_CLK_1L;
      endcase
    end else if (cur != flash_fe_pkg::ST_MODE && cur != flash_fe_pkg::ST_DUMMY
                 && d.modeClk != `NO_MODE) begin
      s.st = flash_fe_pkg::ST_MODE;
      s.cnt = 6'(d.modeClk);
    end else if (cur != flash_fe_pkg::ST_DUMMY && d.dummyClk != `NO_DUMMY) begin
      s.st = flash_fe_pkg::ST_DUMMY;
      s.cnt = d.dummyClk;
    end else if (d.daW != `W0) begin
      s.st = d.dirOut ? flash_fe_pkg::ST_DOUT : flash_fe_pkg::ST_DIN;
    end
    return s;
  endfunction

  // Input lanes: one line uses the first pin, wider groups put the MSB highest.
  function automatic logic [23:0] shiftIn(
    input logic [23:0] sh,
    input logic [3:0] io,
    input logic [2:0] w
  );
    case (w)
      `W2: return {sh[21:0], io[1:0]};
      `W4: return {sh[19:0], io[3:0]};
      default: return {sh[22:0], io[0]};
    endcase
  endfunction

  function automatic flash_fe_pkg::lane_drive_t lanes(
    input logic [7:0] b,
    input logic [2:0] w
  );
    flash_fe_pkg::lane_drive_t r;
    case (w)
      `W2: begin
        r.dat = {2'h0, b[7:6]};
        r.oe = `OE_2L;
      end
      `W4: begin
        r.dat = b[7:4];
        r.oe = `OE_4L;
      end
      default: begin
        r.dat = {2'h0, b[7], 1'h0};
        r.oe = `OE_1L;
      end
    endcase
    return r;
  endfunction

  // ==========================================================
  // Pin synchronisers and edge detection
  // ==========================================================
  logic [5:0] syncQ;
  logic csS;
  logic sckS;
  logic [3:0] ioS;
  logic csRise;
  logic csFall;
  logic sckRise;
  logic sckFall;

  // The host clock is slow against ref_clk, so it is sampled like any pin.
  sync_2ff #(.W(6), .INIT(`SYNC_INIT)) u_sync (
    .clk(ref_clk),
    .rst_n(reset_n),
    .en(clkEn),
    .d({ioIn, sck, csN}),
    .q(syncQ)
  );
  assign csS = syncQ[0];
  assign sckS = syncQ[1];
  assign ioS = syncQ[5:2];

  edge_finder #(.INIT(1'b1)) u_cs_edge (
    .clk(ref_clk),
    .rst_n(reset_n),
    .en(clkEn),
    .lvl(csS),
    .rise(csRise),
    .fall(csFall)
  );
  edge_finder #(.INIT(1'b0)) u_sck_edge (
    .clk(ref_clk),
    .rst_n(reset_n),
    .en(clkEn),
    .lvl(sckS),
    .rise(sckRise),
    .fall(sckFall)
  );

  // ==========================================================
  // Shared decode
  // ==========================================================
  flash_fe_pkg::fe_state_t st_r;
  flash_fe_pkg::cmd_desc_t desc_r;
  flash_fe_pkg::cmd_desc_t opcDesc;
  flash_fe_pkg::cmd_desc_t curDesc;
  flash_fe_pkg::phase_step_t step;
  flash_fe_pkg::lane_drive_t drv;
  flash_fe_pkg::cmd_t cmd_r;
  logic [5:0] phCnt_r;
  logic [7:0] opc_r;
  logic [7:0] opcNext;
  logic [23:0] shIn_r;
  logic [23:0] shNext;
  logic [3:0] bitCnt_r;
  logic [1:0] byteCnt_r;
  logic [21:0] rdAddr_r;
  logic hdrDone_r;
  logic [7:0] outSh_r;
  logic [7:0] srcByte;
  logic [3:0] outLeft_r;
  logic [3:0] ioOut_r;
  logic [3:0] ioOe_r;
  logic cmdValid_r;
  logic wrValid_r;
  logic [7:0] wrByte_r;
  logic hdrPhase;
  logic phaseEnd;
  logic byteInDone;
  logic limitHit;
  logic loadNow;

  assign opcNext = {opc_r[6:0], ioS[0]};
  assign opcDesc = decode(opcNext);
  assign curDesc = (st_r == flash_fe_pkg::ST_OPC) ? opcDesc : desc_r;
  assign step = nextPhase(st_r, curDesc);
  assign hdrPhase = st_r inside {flash_fe_pkg::ST_OPC, flash_fe_pkg::ST_ADDR,
                                 flash_fe_pkg::ST_MODE, flash_fe_pkg::ST_DUMMY};
  assign phaseEnd = sckRise && phCnt_r == `PHASE_LAST;
  assign shNext = shiftIn(shIn_r, ioS,
                          (st_r == flash_fe_pkg::ST_DIN) ? desc_r.daW : desc_r.adW);
  assign byteInDone = sckRise && st_r == flash_fe_pkg::ST_DIN
                      && (bitCnt_r + {1'b0, desc_r.daW}) == `BYTE_BITS;
  assign limitHit = desc_r.maxBytes != `MAX_UNL && byteCnt_r == desc_r.maxBytes;
  assign loadNow = sckFall && st_r == flash_fe_pkg::ST_DOUT
                   && outLeft_r == `NO_BITS && !limitHit;
  assign srcByte = loadNow ? rdByte : outSh_r;
  assign drv = lanes(srcByte, desc_r.daW);

  // ==========================================================
  // Phase sequencer
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= flash_fe_pkg::ST_IDLE;
      phCnt_r <= '0;
      desc_r <= '0;
    end else if (clkEn) begin
      if (csS) begin
        st_r <= flash_fe_pkg::ST_IDLE;
      end else if (csFall) begin
        st_r <= flash_fe_pkg::ST_OPC;
        phCnt_r <= `OPC_CLK;
      end else if (phaseEnd && hdrPhase) begin
        if (st_r == flash_fe_pkg::ST_OPC) begin
          desc_r <= opcDesc;
        end
        if (st_r == flash_fe_pkg::ST_OPC && !opcDesc.known) begin
          st_r <= flash_fe_pkg::ST_IGNORE;
        end else begin
          st_r <= step.st;
          phCnt_r <= step.cnt;
        end
      end else if (sckRise && hdrPhase) begin
        phCnt_r <= phCnt_r - 6'h1;
      end else if (byteInDone && desc_r.maxBytes != `MAX_UNL
                   && byteCnt_r + 2'h1 == desc_r.maxBytes) begin
        st_r <= flash_fe_pkg::ST_IGNORE;
      end else if (sckFall && st_r == flash_fe_pkg::ST_DOUT
                   && outLeft_r == `NO_BITS && limitHit) begin
        st_r <= flash_fe_pkg::ST_IGNORE;
      end
    end
  end

  // ==========================================================
  // Opcode, address and write data capture
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      opc_r <= '0;
      shIn_r <= '0;
      bitCnt_r <= '0;
      byteCnt_r <= '0;
      rdAddr_r <= '0;
      hdrDone_r <= 1'b0;
    end else if (clkEn) begin
      if (csFall) begin
        opc_r <= '0;
        bitCnt_r <= '0;
        byteCnt_r <= '0;
        rdAddr_r <= '0;
        hdrDone_r <= 1'b0;
      end else if (sckRise) begin
        case (st_r)
          flash_fe_pkg::ST_OPC: begin
            opc_r <= opcNext;
            if (phaseEnd && opcDesc.known && opcDesc.adW == `W0) begin
              hdrDone_r <= 1'b1;
            end
          end
          flash_fe_pkg::ST_ADDR: begin
            shIn_r <= shNext;
            if (phaseEnd) begin
              rdAddr_r <= shNext[21:0];
              hdrDone_r <= 1'b1;
            end
          end
          flash_fe_pkg::ST_DIN: begin
            shIn_r <= shNext;
            if (byteInDone) begin
              bitCnt_r <= '0;
              byteCnt_r <= byteCnt_r + 2'h1;
              rdAddr_r <= rdAddr_r + 22'h1;
            end else begin
              bitCnt_r <= bitCnt_r + {1'b0, desc_r.daW};
            end
          end
          default: begin
          end
        endcase
      end else if (loadNow) begin
        // A 22-bit counter wraps from the top location to zero in one step.
        rdAddr_r <= rdAddr_r + 22'h1;
        byteCnt_r <= byteCnt_r + 2'h1;
      end
    end
  end

  // ==========================================================
  // Output lanes
  // ==========================================================
  // Bits change on the falling edge so the host samples them on the next rise.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ioOut_r <= '0;
      ioOe_r <= '0;
      outSh_r <= '0;
      outLeft_r <= '0;
    end else if (clkEn) begin
      if (csS) begin
        ioOe_r <= '0;
        outLeft_r <= `NO_BITS;
      end else if (sckFall && st_r == flash_fe_pkg::ST_DOUT) begin
        if (outLeft_r == `NO_BITS && limitHit) begin
          ioOe_r <= '0;
        end else begin
          ioOut_r <= drv.dat;
          ioOe_r <= drv.oe;
          outSh_r <= srcByte << desc_r.daW;
          outLeft_r <= (loadNow ? `BYTE_BITS : outLeft_r) - {1'b0, desc_r.daW};
        end
      end
    end
  end

  // ==========================================================
  // Command and write strobes
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmdValid_r <= 1'b0;
      cmd_r <= '0;
      wrValid_r <= 1'b0;
      wrByte_r <= '0;
    end else if (clkEn) begin
      // Erase and suspend act only once select closes a complete header.
      cmdValid_r <= csRise && hdrDone_r;
      if (phaseEnd && st_r == flash_fe_pkg::ST_OPC) begin
        cmd_r.opcode <= opcNext;
        cmd_r.addr <= '0;
      end else if (phaseEnd && st_r == flash_fe_pkg::ST_ADDR) begin
        cmd_r.addr <= shNext[21:0];
      end
      wrValid_r <= byteInDone;
      if (byteInDone) begin
        wrByte_r <= shNext[7:0];
      end
    end
  end

  assign ioOut = ioOut_r;
  assign ioOe = ioOe_r;
  assign rdAddr = rdAddr_r;
  assign rdSrc = opc_r;
  assign cmdValid = cmdValid_r;
  assign cmd = cmd_r;
  assign wrValid = wrValid_r;
  assign wrByte = wrByte_r;

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_unknown_ignored;
    @(posedge ref_clk) disable iff (!reset_n || !clkEn)
    (phaseEnd && st_r == flash_fe_pkg::ST_OPC && !opcDesc.known && !csS && !csFall)
      |=> st_r == flash_fe_pkg::ST_IGNORE;
  endproperty
  a_unknown_ignored: assert property (p_unknown_ignored) else $error("bad opcode not ignored");

  property p_ignore_quiet;
    @(posedge ref_clk) disable iff (!reset_n || !clkEn)
    st_r == flash_fe_pkg::ST_IGNORE |-> ioOe_r == 4'h0;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("driving while ignoring");

  property p_release_hiz;
    @(posedge ref_clk) disable iff (!reset_n || !clkEn)
    csRise |=> ioOe_r == 4'h0 && st_r == flash_fe_pkg::ST_IDLE;
  endproperty
  a_release_hiz: assert property (p_release_hiz) else $error("pins not released");

  property p_wrap;
    @(posedge ref_clk) disable iff (!reset_n || !clkEn)
    (loadNow && rdAddr_r == `ADDR_TOP && !csFall) |=> rdAddr_r == 22'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not wrap");

  property p_uid_dummy;
    @(posedge ref_clk) disable iff (!reset_n || !clkEn)
    (phaseEnd && st_r == flash_fe_pkg::ST_OPC && opcNext == `OPC_UID && !csS && !csFall)
      |=> st_r == flash_fe_pkg::ST_DUMMY && phCnt_r == `DUMMY_32;
  endproperty
  a_uid_dummy: assert property (p_uid_dummy) else $error("unique id dummy wrong");

  property p_param_dummy;
    @(posedge ref_clk) disable iff (!reset_n || !clkEn)
    (phaseEnd && st_r == flash_fe_pkg::ST_ADDR && opc_r inside {`OPC_PARAM, `OPC_SECR}
     && !csS && !csFall) |=> st_r == flash_fe_pkg::ST_DUMMY && phCnt_r == `DUMMY_8;
  endproperty
  a_param_dummy: assert property (p_param_dummy) else $error("dummy count wrong");

  property p_id_dual;
    @(posedge ref_clk) disable iff (!reset_n || !clkEn)
    (phaseEnd && st_r == flash_fe_pkg::ST_ADDR && opc_r inside {`OPC_ID2, `OPC_ID4}
     && !csS && !csFall) |=> st_r == flash_fe_pkg::ST_DUMMY && phCnt_r == `DUMMY_4;
  endproperty
  a_id_dual: assert property (p_id_dual) else $error("id dummy wrong");

  property p_erase_nodata;
    @(posedge ref_clk) disable iff (!reset_n || !clkEn)
    (phaseEnd && st_r == flash_fe_pkg::ST_ADDR && !csS && !csFall
     && opc_r inside {`OPC_BE4, `OPC_BE32, `OPC_BE64, `OPC_SECE})
      |=> st_r == flash_fe_pkg::ST_IGNORE;
  endproperty
  a_erase_nodata: assert property (p_erase_nodata) else $error("erase took data");

  property p_status_one;
    @(posedge ref_clk) disable iff (!reset_n || !clkEn)
    (sckFall && st_r == flash_fe_pkg::ST_DOUT && byteCnt_r == `MAX_1 && !csS && !csFall
     && outLeft_r == `NO_BITS && opc_r inside {`OPC_RSR1, `OPC_RSR2, `OPC_RSR3})
      |=> st_r == flash_fe_pkg::ST_IGNORE ##1 ioOe_r == 4'h0;
  endproperty
  a_status_one: assert property (p_status_one) else $error("status sent extra byte");

  property p_fall_only;
    @(posedge ref_clk) disable iff (!reset_n || !clkEn)
    $changed(ioOut_r) |-> $past(sckFall);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("data changed off fall");

  property p_dual_mode;
    @(posedge ref_clk) disable iff (!reset_n || !clkEn)
    (phaseEnd && st_r == flash_fe_pkg::ST_ADDR && opc_r == `OPC_DIORD && !csS && !csFall)
      |=> st_r == flash_fe_pkg::ST_MODE && phCnt_r == 6'(`MODE_CLK_2L);
  endproperty
  a_dual_mode: assert property (p_dual_mode) else $error("dual mode clocks wrong");

  c_read_data: cover property (@(posedge ref_clk) loadNow && opc_r == `OPC_RD);
  c_wrap: cover property (@(posedge ref_clk) loadNow && rdAddr_r == `ADDR_TOP);
  c_write_byte: cover property (@(posedge ref_clk) wrValid_r);
  c_ignore: cover property (@(posedge ref_clk) st_r == flash_fe_pkg::ST_IGNORE);
endmodule

// ==== verification/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model (
  // Clock that paces the host
  input wire logic ref_clk,
  // Serial link
  input wire logic so,
  output logic csN,
  output logic sck,
  output logic si
);
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // ============================================================
  // Framing
  // ============================================================
  // Clock mode 0: the link clock idles low and only runs inside a frame.
  task automatic start();
    wt(1);
    csN = 1'b0;
    wt(4);
  endtask
  task automatic stop();
    wt(4);
    csN = 1'b1;
    si = ~si;
    wt(6);
  endtask
  // ============================================================
  // Bit shifting
  // ============================================================
  // Half period of four clocks gives the 800 ns link period.
  task automatic shift(input logic [31:0] d, input int n, output logic [31:0] q);
    q = '0;
    for (int i = n - 1; i >= 0; i--) begin
      si = d[i];
      wt(4);
      sck = 1'b1;
      q = {q[30:0], so};
      wt(4);
      sck = 1'b0;
    end
  endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] op; logic [23:0] a; int na; int nx; logic [31:0] dx; int nrd;
    logic [15:0] ex; logic [29:0] ec;} row_t;
  logic refClk, resetN, clkEn, csN, sck, si, cmdValid, wrValid;
  logic [3:0] ioOut, ioOe;
  logic [21:0] rdAddr;
  logic [7:0] rdSrc, wrByte, lastWr;
  logic [31:0] q;
  flash_fe_pkg::cmd_t cmd, lastCmd;
  int nFail = 0, samplesChecked = 0, nCmd = 0, nWr = 0;
  // Undriven lanes toggle with the link clock so a stale value cannot pass.
  wire logic [3:0] ioIn = {(ioOut[3:1] & ioOe[3:1]) | (~ioOe[3:1] & {3{sck}}), si};
  wire logic [7:0] rdByte = rdAddr[7:0] ^ rdSrc;
  row_t rows [12] = '{
    '{8'h03, 24'h000010, 24, 0, 0, 16, 16'h1312, {8'h03, 22'h10}},
    '{8'h0b, 24'hffffff, 24, 8, 0, 16, 16'hf40b, {8'h0b, 22'h3fffff}},
    '{8'h05, 0, 0, 0, 0, 8, 16'h05, {8'h05, 22'h0}},
    '{8'h20, 24'h123456, 24, 0, 0, 0, 0, {8'h20, 22'h123456}},
    '{8'h75, 0, 0, 0, 0, 0, 0, {8'h75, 22'h0}},
    '{8'h01, 0, 0, 8, 8'ha5, 0, 0, {8'h01, 22'h0}},
    '{8'h4b, 0, 0, 32, 0, 8, 16'h4b, {8'h4b, 22'h0}},
    '{8'h48, 24'h20, 24, 8, 0, 8, 16'h68, {8'h48, 22'h20}},
    '{8'h5a, 24'h30, 24, 8, 0, 8, 16'h6a, {8'h5a, 22'h30}},
    '{8'h90, 24'h0, 24, 0, 0, 16, 16'h9091, {8'h90, 22'h0}},
    '{8'h44, 24'h000400, 24, 0, 0, 0, 0, {8'h44, 22'h400}},
    '{8'h42, 24'h000010, 24, 16, 32'h5aa5, 0, 0, {8'h42, 22'h10}}
  };
  serial_flash_front_end dut (.ref_clk(refClk), .reset_n(resetN), .clkEn, .csN, .sck,
    .ioIn, .ioOut, .ioOe, .rdAddr, .rdSrc, .rdByte, .cmdValid, .cmd, .wrValid, .wrByte);
  spi_host_model host (.ref_clk(refClk), .so(ioIn[1]), .csN(csN), .sck(sck), .si(si));
  initial begin
    refClk = 1'b0;
    forever #50 refClk = ~refClk;
  end
  // Strobes are read mid-cycle, where they have settled.
  always @(negedge refClk) begin
    if (cmdValid === 1'b1) begin
      nCmd++;
      lastCmd = cmd;
    end
    if (wrValid === 1'b1) begin
      nWr++;
      lastWr = wrByte;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samplesChecked++;
    if (s !== e) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    if (nFail == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    clkEn = 1'b1;
    resetN = 1'b0;
    repeat (6) @(negedge refClk);
    resetN = 1'b1;
    repeat (4) @(negedge refClk);
    chk("ioOe after reset", 0, ioOe);
    foreach (rows[i]) begin
      host.start();
      host.shift(rows[i].op, 8, q);
      host.shift(rows[i].a, rows[i].na, q);
      host.shift(rows[i].dx, rows[i].nx, q);
      host.shift(0, rows[i].nrd, q);
      if (rows[i].nrd > 0) chk("read data", rows[i].ex, q);
      if (rows[i].nrd > 0 && rows[i].op != 8'h05) chk("ioOe reading", 4'h2, ioOe);
      host.stop();
      chk("ioOe released", 0, ioOe);
      chk("cmd", rows[i].ec, lastCmd);
    end
    chk("command count", 12, nCmd);
    chk("write byte", 8'ha5, lastWr);
    chk("write count", 3, nWr);
    // An unknown opcode must leave the lanes floating and report nothing.
    host.start();
    host.shift(8'h77, 8, q);
    host.shift(24'h000005, 24, q);
    host.shift(0, 8, q);
    chk("ioOe unknown", 0, ioOe);
    host.stop();
    chk("count unknown", 12, nCmd);
    // Select dropped in the middle of the address.
    host.start();
    host.shift(8'h03, 8, q);
    host.shift(8'h12, 8, q);
    host.stop();
    chk("count abandoned", 12, nCmd);
    // Quad output read: the second nibble of the first byte on all four lanes.
    host.start();
    host.shift(8'h6b, 8, q);
    host.shift(24'h000040, 24, q);
    host.shift(0, 9, q);
    host.wt(4);
    chk("quad lanes", 4'hb, ioOut);
    chk("quad oe", 4'hf, ioOe);
    host.stop();
    // A frozen block must miss a whole erase.
    clkEn = 1'b0;
    host.start();
    host.shift(8'h20, 8, q);
    host.shift(24'h000010, 24, q);
    host.stop();
    clkEn = 1'b1;
    host.wt(4);
    chk("count frozen", 13, nCmd);
    // Reset in the middle of a read drops the lanes and forgets the command.
    host.start();
    host.shift(8'h03, 8, q);
    host.shift(24'h000050, 24, q);
    host.shift(0, 4, q);
    resetN = 1'b0;
    host.wt(2);
    chk("ioOe in reset", 0, ioOe);
    chk("rdAddr in reset", 0, rdAddr);
    host.stop();
    resetN = 1'b1;
    host.wt(4);
    chk("count after reset", 13, nCmd);
    close_out();
  end
  initial begin
    #3000000;
    nFail++;
    close_out();
  end
endmodule
